/* File: logic/pdrr_client.sv */
// client end: timestamp gathering, offset and delay, frequency steering
// Function
// [RL1] server sends sync, keeps send time t1
// [RL2] client stamps sync arrival as t2
// [RL3] follow-up carries t1 to client
// [RL4] client sends delay request, keeps t3
// [RL5] server stamps request arrival as t4
// [RL6] delay response carries t4 to client
// [RL7] with four stamps compute offset and delay
// [RL8] delay is mean of both legs
// [RL9] steer local frequency to match server
// [RL10] relay adds residence time to correction
// [RL11] transparent relay forwards every message onward
// [RL12] single-port server feeds timing to clients
// [RL13] at most two servers tracked at once
// [RL14] relay serves itself when nothing better seen
// [RL15] offset is half of leg difference
// [RL16] stamps taken when message passes port
`timescale 1ns/1ps
`default_nettype none
module pdrr_client #(
   parameter logic [19:0] TIMEOUT_CYCLES = 20'(pdrr_pkg::TIMEOUT_CYC)
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   pdrr_link_if.client link,
   input wire logic [1:0] slot_en_in,
   input wire logic steer_slot_in,
   input wire logic req_go_in,
   output logic [47:0] time_out,
   output logic [1:0][47:0] offset_out,
   output logic [1:0][47:0] delay_out,
   output logic [31:0] freq_adj_out,
   output logic done_out,
   output logic done_slot_out,
   output logic timeout_out,
   output logic busy_out
);
   import pdrr_pkg::*;

   typedef struct packed {
      pdrr_cst_e st;
      logic [63:0] clk;
      logic signed [31:0] adj;
      logic slot;
      logic [47:0] t1;
      logic [47:0] t2;
      logic [47:0] t3;
      logic [47:0] t4;
      logic [31:0] c_ms;
      logic [31:0] c_sm;
      logic [19:0] wait_cnt;
      logic [1:0][47:0] offs;
      logic [1:0][47:0] dly;
      logic c2s_valid;
      logic c2s_slot;
      logic done;
      logic timeout;
      logic busy;
   } pdrr_cli_s;

   pdrr_cli_s r;
   pdrr_cli_s next_r;
   logic [47:0] now;
   logic hit;
   logic same;
   logic signed [47:0] ms;
   logic signed [47:0] sm;
   logic signed [47:0] offs_v;

   // ==========================================================
   // helpers
   function automatic logic [47:0] pdrr_sext(input logic [31:0] v);
      return {{16{v[31]}}, v};
   endfunction

   // sum of two legs halved, one guard bit against overflow
   function automatic logic [47:0] pdrr_half(input logic signed [47:0] a,
                                             input logic signed [47:0] b);
      logic signed [48:0] s;
      s = 49'(a) + 49'(b);
      return s[48:1];
   endfunction

   // proportional steer; clamped so a wild sample cannot run away
   function automatic logic [31:0] pdrr_steer(input logic signed [31:0] a,
                                              input logic signed [47:0] o);
      logic signed [47:0] v;
      v = $signed(pdrr_sext(a)) - (o >>> STEER_SHIFT);
      if (v > ADJ_LIMIT) begin
         v = ADJ_LIMIT;
      end else if (v < -ADJ_LIMIT) begin
         v = -ADJ_LIMIT;
      end
      return v[31:0];
   endfunction

   // ==========================================================
   // next state
   always_comb begin
      next_r = r;
      // local time runs at nominal rate plus the steering term
      next_r.clk = r.clk + NOM_INC + {{32{r.adj[31]}}, r.adj}; // [RL9]
      next_r.c2s_valid = 1'b0;
      next_r.done = 1'b0;
      next_r.timeout = 1'b0;
      now = r.clk[63:FRAC_BITS];
      // the slot bit only names two servers, enables pick which
      hit = link.s2c_valid && slot_en_in[link.s2c_slot]; // [RL13]
      same = hit && (link.s2c_slot == r.slot);
      ms = $signed(r.t2 - r.t1 - pdrr_sext(r.c_ms));
      sm = $signed(r.t4 - r.t3 - pdrr_sext(r.c_sm));
      offs_v = $signed(pdrr_half(ms, -sm));
      case (r.st)
         PDRR_IDLE: begin
            if (hit && (link.s2c_kind == PDRR_SYNC)) begin
               next_r.t2 = now; // [RL2] [RL16]
               next_r.slot = link.s2c_slot;
               next_r.c_ms = link.s2c_corr;
               next_r.wait_cnt = 20'h0;
               next_r.st = PDRR_WAIT_FU;
            end
         end
         PDRR_WAIT_FU: begin
            next_r.wait_cnt = r.wait_cnt + 20'h1;
            if (same && (link.s2c_kind == PDRR_FOLLOW)) begin
               next_r.t1 = link.s2c_stamp; // [RL3]
               next_r.c_ms = r.c_ms + link.s2c_corr;
               next_r.st = PDRR_SEND_REQ;
            end else if (same && (link.s2c_kind == PDRR_SYNC)) begin
               // a newer sync replaces one whose follow-up was lost
               next_r.t2 = now; // [RL2]
               next_r.c_ms = link.s2c_corr;
               next_r.wait_cnt = 20'h0;
            end else if (r.wait_cnt == TIMEOUT_CYCLES - 20'h1) begin
               next_r.timeout = 1'b1;
               next_r.st = PDRR_IDLE;
            end
         end
         PDRR_SEND_REQ: begin
            if (req_go_in) begin
               next_r.c2s_valid = 1'b1; // [RL4]
               next_r.c2s_slot = r.slot;
               // stamp matches the cycle the request is on the port
               next_r.t3 = next_r.clk[63:FRAC_BITS]; // [RL4] [RL16]
               next_r.wait_cnt = 20'h0;
               next_r.st = PDRR_WAIT_RESP;
            end
         end
         PDRR_WAIT_RESP: begin
            next_r.wait_cnt = r.wait_cnt + 20'h1;
            if (same && (link.s2c_kind == PDRR_RESP)) begin
               next_r.t4 = link.s2c_stamp; // [RL6]
               next_r.c_sm = link.s2c_corr;
               next_r.st = PDRR_CALC;
            end else if (r.wait_cnt == TIMEOUT_CYCLES - 20'h1) begin
               next_r.timeout = 1'b1;
               next_r.st = PDRR_IDLE;
            end
         end
         PDRR_CALC: begin
            // offset: half of (t2-t1) minus (t4-t3)
            next_r.offs[r.slot] = offs_v; // [RL7] [RL15]
            // delay: mean of both legs, assumes a symmetric path
            next_r.dly[r.slot] = pdrr_half(ms, sm); // [RL7] [RL8]
            if (r.slot == steer_slot_in) begin
               next_r.adj = pdrr_steer(r.adj, offs_v); // [RL9]
            end
            next_r.done = 1'b1;
            next_r.st = PDRR_IDLE;
         end
         default: begin
            next_r.st = PDRR_IDLE;
         end
      endcase
      next_r.busy = (next_r.st != PDRR_IDLE);
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         r <= '0;
         r.st <= PDRR_IDLE;
         r.clk <= CLK_RST;
         r.adj <= ADJ_RST;
      end else begin
         r <= next_r;
      end
   end

   assign link.c2s_valid = r.c2s_valid;
   assign link.c2s_slot = r.c2s_slot;
   assign time_out = r.clk[63:FRAC_BITS];
   assign offset_out = r.offs;
   assign delay_out = r.dly;
   assign freq_adj_out = r.adj;
   assign done_out = r.done;
   assign done_slot_out = r.slot;
   assign timeout_out = r.timeout;
   assign busy_out = r.busy;
endmodule
`default_nettype wire

/* File: logic/pdrr_pkg.sv */
// shared constants and types for the delay request-response timestamp exchange
package pdrr_pkg;
   // ==========================================================
   // clock and time base
   localparam int CLK_NS = 10;
   localparam int FRAC_BITS = 16;
   localparam logic [47:0] CLK_STEP = 48'(CLK_NS);
   localparam logic [63:0] NOM_INC = 64'(CLK_NS) << FRAC_BITS;
   localparam logic [47:0] TIME_RST = 48'h0;
   localparam logic [63:0] CLK_RST = 64'h0;
   // ==========================================================
   // client timing and steering
   localparam int TIMEOUT_US = 1000;
   localparam int TIMEOUT_CYC = (TIMEOUT_US * 1000) / CLK_NS;
   localparam int STEER_SHIFT = 4;
   localparam logic signed [47:0] ADJ_LIMIT = 48'sh0000_0000_4000;
   localparam logic signed [31:0] ADJ_RST = 32'sh0;
   localparam int SLOT_N = 2;
   // ==========================================================
   // message kinds, modes, states
   typedef enum logic [1:0] {
      PDRR_SYNC = 2'h0,
      PDRR_FOLLOW = 2'h1,
      PDRR_RESP = 2'h2
   } pdrr_kind_e;
   typedef enum logic [2:0] {
      PDRR_SERVER = 3'h1,
      PDRR_RELAY = 3'h2,
      PDRR_TRANSP = 3'h4
   } pdrr_mode_e;
   typedef enum logic [4:0] {
      PDRR_IDLE = 5'h01,
      PDRR_WAIT_FU = 5'h02,
      PDRR_SEND_REQ = 5'h04,
      PDRR_WAIT_RESP = 5'h08,
      PDRR_CALC = 5'h10
   } pdrr_cst_e;
endpackage

/* File: logic/pdrr_link_if.sv */
// message link between the server end and the client end
`timescale 1ns/1ps
`default_nettype none
interface pdrr_link_if;
   import pdrr_pkg::*;
   // ==========================================================
   // server to client
   logic s2c_valid;
   pdrr_kind_e s2c_kind;
   logic s2c_slot;
   logic [47:0] s2c_stamp;
   logic [31:0] s2c_corr;
   // ==========================================================
   // client to server (delay request)
   logic c2s_valid;
   logic c2s_slot;
   modport server (
      output s2c_valid, s2c_kind, s2c_slot, s2c_stamp, s2c_corr,
      input c2s_valid, c2s_slot
   );
   modport client (
      input s2c_valid, s2c_kind, s2c_slot, s2c_stamp, s2c_corr,
      output c2s_valid, c2s_slot
   );
endinterface
`default_nettype wire

/* File: logic/pdrr_server.sv */
// server end: sync, follow-up, delay response, relay and residence correction
`timescale 1ns/1ps
`default_nettype none
module pdrr_server #(
   parameter logic SLOT_ID = 1'b0
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   pdrr_link_if.server link,
   input wire pdrr_pkg::pdrr_mode_e mode_in,
   input wire logic better_in,
   input wire logic sync_req_in,
   input wire logic fwd_valid_in,
   input wire pdrr_pkg::pdrr_kind_e fwd_kind_in,
   input wire logic fwd_slot_in,
   input wire logic [47:0] fwd_stamp_in,
   input wire logic [31:0] fwd_corr_in,
   output logic fwd_ready_out,
   output logic up_valid_out,
   output logic up_slot_out,
   output logic active_out,
   output logic [47:0] time_out
);
   import pdrr_pkg::*;

   typedef struct packed {
      logic [47:0] tm;
      logic [47:0] t1;
      logic [47:0] t4;
      logic sync_pend;
      logic fu_pend;
      logic resp_pend;
      logic resp_slot;
      logic h_full;
      pdrr_kind_e h_kind;
      logic h_slot;
      logic [47:0] h_stamp;
      logic [31:0] h_corr;
      logic [47:0] h_arr;
      logic fwd_ready;
      logic o_valid;
      pdrr_kind_e o_kind;
      logic o_slot;
      logic [47:0] o_stamp;
      logic [31:0] o_corr;
      logic up_valid;
      logic up_slot;
      logic active;
   } pdrr_srv_s;

   pdrr_srv_s r;
   pdrr_srv_s next_r;
   logic act;
   logic [47:0] resid;

   // ==========================================================
   // next state
   always_comb begin
      next_r = r;
      next_r.tm = r.tm + CLK_STEP;
      next_r.o_valid = 1'b0;
      next_r.up_valid = 1'b0;
      // acts as server in server mode, or as a relay that sees no better clock upstream; never in transparent mode
      act = (mode_in == PDRR_SERVER) ||
            ((mode_in == PDRR_RELAY) && !better_in); // [RL12] [RL14]
      next_r.active = act;
      resid = next_r.tm - r.h_arr;
      // one message per cycle; answers go first to keep t4 fresh
      if (r.resp_pend) begin
         next_r.o_valid = 1'b1;
         next_r.o_kind = PDRR_RESP;
         next_r.o_slot = r.resp_slot;
         next_r.o_stamp = r.t4; // [RL6]
         next_r.o_corr = 32'h0;
         next_r.resp_pend = 1'b0;
      end else if (r.fu_pend) begin
         next_r.o_valid = 1'b1;
         next_r.o_kind = PDRR_FOLLOW;
         next_r.o_slot = SLOT_ID;
         next_r.o_stamp = r.t1; // [RL3]
         next_r.o_corr = 32'h0;
         next_r.fu_pend = 1'b0;
      end else if (r.sync_pend && act) begin
         next_r.o_valid = 1'b1;
         next_r.o_kind = PDRR_SYNC; // [RL1]
         next_r.o_slot = SLOT_ID;
         next_r.o_stamp = 48'h0;
         next_r.o_corr = 32'h0;
         // stamp is the time of the cycle the message is on the port
         next_r.t1 = next_r.tm; // [RL1] [RL16]
         next_r.fu_pend = 1'b1;
         next_r.sync_pend = 1'b0;
      end else if (r.h_full) begin
         next_r.o_valid = 1'b1; // [RL11]
         next_r.o_kind = r.h_kind;
         next_r.o_slot = r.h_slot;
         next_r.o_stamp = r.h_stamp;
         next_r.o_corr = r.h_corr + resid[31:0]; // [RL10]
         next_r.h_full = 1'b0;
      end
      // sets come after clears so a same-cycle event wins
      if (sync_req_in && act) begin
         next_r.sync_pend = 1'b1;
      end
      if (!act) begin
         next_r.sync_pend = 1'b0;
      end
      if (link.c2s_valid) begin
         if (act && (link.c2s_slot == SLOT_ID)) begin
            next_r.t4 = r.tm; // [RL5] [RL16]
            next_r.resp_pend = 1'b1;
            next_r.resp_slot = link.c2s_slot;
         end else if (!act) begin
            // upstream requests carry no correction field here
            next_r.up_valid = 1'b1; // [RL11]
            next_r.up_slot = link.c2s_slot;
         end
      end
      if (fwd_valid_in && r.fwd_ready) begin
         next_r.h_full = 1'b1;
         next_r.h_kind = fwd_kind_in;
         next_r.h_slot = fwd_slot_in;
         next_r.h_stamp = fwd_stamp_in;
         next_r.h_corr = fwd_corr_in;
         next_r.h_arr = r.tm; // [RL10]
      end
      next_r.fwd_ready = !next_r.h_full && !act;
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         r <= '0;
         r.tm <= TIME_RST;
         r.h_kind <= PDRR_SYNC;
         r.o_kind <= PDRR_SYNC;
      end else begin
         r <= next_r;
      end
   end

   assign link.s2c_valid = r.o_valid;
   assign link.s2c_kind = r.o_kind;
   assign link.s2c_slot = r.o_slot;
   assign link.s2c_stamp = r.o_stamp;
   assign link.s2c_corr = r.o_corr;
   assign fwd_ready_out = r.fwd_ready;
   assign up_valid_out = r.up_valid;
   assign up_slot_out = r.up_slot;
   assign active_out = r.active;
   assign time_out = r.tm;
endmodule
`default_nettype wire

/* File: verification/pdrr_link_properties.sv */
// concurrent checks on the server-client message link
`timescale 1ns/1ps
`default_nettype none
module pdrr_link_properties (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic s2c_valid,
   input wire pdrr_pkg::pdrr_kind_e s2c_kind,
   input wire logic s2c_slot,
   input wire logic [47:0] s2c_stamp,
   input wire logic [31:0] s2c_corr,
   input wire logic c2s_valid,
   input wire logic c2s_slot
);
   import pdrr_pkg::*;
   // ======================================
   // helper logic
   // ns mirrors the server time base, both start from zero at release
   logic [47:0] ns;
   logic [47:0] t1_seen;
   logic srv_sync, srv_follow, fol, resp;
   assign srv_sync = s2c_valid && s2c_kind == PDRR_SYNC && !s2c_slot;
   assign fol = s2c_valid && s2c_kind == PDRR_FOLLOW;
   assign srv_follow = fol && !s2c_slot;
   assign resp = s2c_valid && s2c_kind == PDRR_RESP;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ns <= TIME_RST;
         t1_seen <= TIME_RST;
      end else begin
         ns <= ns + CLK_STEP;
         if (srv_sync) begin
            t1_seen <= ns;
         end
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // ======================================
   // properties
   // a pending response may push the follow-up back
   a_sync_then_follow: assert property (
      srv_sync |-> ##[1:3] srv_follow)
      else $error("follow-up missing after sync");
   a_follow_stamp: assert property (
      srv_follow |-> s2c_stamp == t1_seen)
      else $error("follow-up stamp differs from sync send time");
   a_sync_two_step: assert property (srv_sync |->
      s2c_stamp == TIME_RST && s2c_corr == 32'h0)
      else $error("own sync carries stamp or correction");
   a_resp_stamp: assert property (c2s_valid && !c2s_slot |->
      ##2 resp && !s2c_slot && s2c_stamp == $past(ns, 2))
      else $error("response late or wrong arrival stamp");
   a_req_after_follow: assert property (srv_follow |->
      ##2 c2s_valid && !c2s_slot)
      else $error("delay request not sent after follow-up");
   a_req_needs_follow: assert property (c2s_valid |-> $past(fol, 2))
      else $error("delay request without follow-up");
   a_resp_needs_req: assert property (resp |-> $past(c2s_valid, 2))
      else $error("response without delay request");
   a_req_pulse: assert property (c2s_valid |=> !c2s_valid)
      else $error("delay request longer than one cycle");
endmodule
`default_nettype wire

/* File: verification/ptp_delay_request_response_bench.sv */
// self-checking bench joining server end and client end
`timescale 1ns/1ps
`default_nettype none
module ptp_delay_request_response_bench;
   import pdrr_pkg::*;
   // short timeout keeps the refused-response case brief
   localparam int TO_CYC = 50;
   logic clk_in = 1'h0;
   logic rstn_in = 1'h0;
   // server leaves reset later so the two time bases start apart
   logic srv_rstn = 1'h0;
   pdrr_mode_e mode_in = PDRR_SERVER;
   logic better_in = 1'h0;
   logic sync_req_in = 1'h0;
   logic fwd_valid_in = 1'h0;
   pdrr_kind_e fwd_kind_in = PDRR_SYNC;
   logic fwd_slot_in = 1'h0;
   logic [47:0] fwd_stamp_in = 48'h0;
   logic [31:0] fwd_corr_in = 32'h0;
   logic [1:0] slot_en_in = 2'h1;
   logic steer_slot_in = 1'h0;
   logic req_go_in = 1'h1;
   logic fwd_ready_out, up_valid_out, up_slot_out, active_out, up_slot;
   logic done_out, done_slot_out, timeout_out, busy_out;
   logic [47:0] srv_time, cli_time, t1, t2, t3, t4, t1s, t4s, lstamp;
   logic [1:0][47:0] offset_out, delay_out;
   logic [31:0] freq_adj_out, lcorr;
   logic signed [47:0] a, b, off, adj_e;
   int cnt [4] = '{default: 0};
   int n_fail = 0;
   int n_checks = 0;
   pdrr_mode_e mtab [4] = '{PDRR_SERVER, PDRR_RELAY, PDRR_RELAY, PDRR_TRANSP};
   logic btab [4] = '{1'h0, 1'h0, 1'h1, 1'h0};
   logic atab [4] = '{1'h1, 1'h1, 1'h0, 1'h0};
   always #5 clk_in = ~clk_in;
   pdrr_link_if lk();
   pdrr_server #(.SLOT_ID(1'h0)) i_pdrr_server (.clk_in(clk_in),
      .rstn_in(srv_rstn), .link(lk), .mode_in(mode_in), .better_in(better_in),
      .sync_req_in(sync_req_in), .fwd_valid_in(fwd_valid_in),
      .fwd_kind_in(fwd_kind_in), .fwd_slot_in(fwd_slot_in),
      .fwd_stamp_in(fwd_stamp_in), .fwd_corr_in(fwd_corr_in),
      .fwd_ready_out(fwd_ready_out), .up_valid_out(up_valid_out),
      .up_slot_out(up_slot_out), .active_out(active_out),
      .time_out(srv_time));
   pdrr_client #(.TIMEOUT_CYCLES(20'(TO_CYC))) i_pdrr_client (
      .clk_in(clk_in), .rstn_in(rstn_in), .link(lk),
      .slot_en_in(slot_en_in), .steer_slot_in(steer_slot_in),
      .req_go_in(req_go_in), .time_out(cli_time), .offset_out(offset_out),
      .delay_out(delay_out), .freq_adj_out(freq_adj_out),
      .done_out(done_out), .done_slot_out(done_slot_out),
      .timeout_out(timeout_out), .busy_out(busy_out));
   pdrr_link_properties i_pdrr_link_properties (.clk_in(clk_in),
      .rstn_in(srv_rstn), .s2c_valid(lk.s2c_valid), .s2c_kind(lk.s2c_kind),
      .s2c_slot(lk.s2c_slot), .s2c_stamp(lk.s2c_stamp),
      .s2c_corr(lk.s2c_corr), .c2s_valid(lk.c2s_valid),
      .c2s_slot(lk.c2s_slot));
   // ======================================
   // link monitor, samples values standing before each edge
   always @(posedge clk_in) begin
      if (lk.s2c_valid === 1'h1 && lk.s2c_slot === 1'h0) begin
         if (lk.s2c_kind === PDRR_SYNC) begin
            t1s <= srv_time;
            t2 <= cli_time;
         end
         if (lk.s2c_kind === PDRR_FOLLOW) t1 <= lk.s2c_stamp;
         if (lk.s2c_kind === PDRR_RESP) t4 <= lk.s2c_stamp;
      end
      if (lk.s2c_valid === 1'h1 && lk.s2c_slot === 1'h1) begin
         lcorr <= lk.s2c_corr;
         lstamp <= lk.s2c_stamp;
         cnt[3] <= cnt[3] + 1;
      end
      if (lk.c2s_valid === 1'h1) begin
         t3 <= cli_time;
         t4s <= srv_time;
      end
      if (done_out === 1'h1) cnt[0] <= cnt[0] + 1;
      if (timeout_out === 1'h1) cnt[1] <= cnt[1] + 1;
      if (up_valid_out === 1'h1) begin
         cnt[2] <= cnt[2] + 1;
         up_slot <= up_slot_out;
      end
   end
   // ======================================
   // tasks
   task check(input logic [63:0] seen, input logic [63:0] exp,
      input string what);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s seen %0h expected %0h", $time, what, seen,
            exp);
      end
   endtask
   task wait_cnt(input int k, input int goal);
      int n;
      n = 0;
      while (cnt[k] < goal && n < 300) begin
         @(negedge clk_in);
         n++;
      end
      if (cnt[k] < goal) begin
         n_fail++;
         $display("[FAIL] %0t no event of kind %0d", $time, k);
      end
   endtask
   task exchange();
      int g;
      g = cnt[0] + 1;
      @(posedge clk_in);
      sync_req_in <= 1'h1;
      @(posedge clk_in);
      sync_req_in <= 1'h0;
      wait_cnt(0, g);
      check(t1, t1s, "sync send stamp");
      check(t4, t4s, "request arrival stamp");
      check(done_slot_out, 1'h0, "done slot");
      a = t2 - t1;
      b = t4 - t3;
      off = (a - b) >>> 1;
      check(offset_out[0], $unsigned(off), "offset");
      check(delay_out[0], $unsigned((a + b) >>> 1), "delay");
      adj_e = adj_e - (off >>> STEER_SHIFT);
      if (adj_e > ADJ_LIMIT) adj_e = ADJ_LIMIT;
      else if (adj_e < -ADJ_LIMIT) adj_e = -ADJ_LIMIT;
      check(freq_adj_out, adj_e[31:0], "frequency step");
   endtask
   task send_fwd(input pdrr_kind_e k, input logic [47:0] st,
      input logic [31:0] c);
      int g;
      g = cnt[3] + 1;
      // looked at off the edge, where the registered ready is settled
      check(fwd_ready_out, 1'h1, "forward ready");
      @(posedge clk_in);
      fwd_valid_in <= 1'h1;
      fwd_kind_in <= k;
      fwd_slot_in <= 1'h1;
      fwd_stamp_in <= st;
      fwd_corr_in <= c;
      @(posedge clk_in);
      fwd_valid_in <= 1'h0;
      wait_cnt(3, g);
   endtask
   task report_and_stop();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ======================================
   // tests
   initial begin
      #50000;
      n_fail++;
      $display("[FAIL] %0t watchdog expired", $time);
      report_and_stop();
   end
   initial begin
      adj_e = ADJ_RST;
      repeat (5) @(posedge clk_in);
      rstn_in <= 1'h1;
      // a client ahead of the server gives a real offset to steer on
      repeat (3) @(posedge clk_in);
      srv_rstn <= 1'h1;
      repeat (3) @(negedge clk_in);
      t1s = srv_time;
      @(negedge clk_in);
      check(srv_time - t1s, CLK_STEP, "time base step");
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_in);
         mode_in <= mtab[i];
         better_in <= btab[i];
         repeat (3) @(negedge clk_in);
         check(active_out, atab[i], "server role");
      end
      $display("test roles done");
      @(posedge clk_in);
      mode_in <= PDRR_SERVER;
      repeat (3) @(negedge clk_in);
      for (int i = 0; i < 4; i++) exchange();
      $display("test exchanges done");
      @(posedge clk_in);
      mode_in <= PDRR_TRANSP;
      slot_en_in <= 2'h3;
      repeat (3) @(negedge clk_in);
      send_fwd(PDRR_SYNC, 48'h0, 32'h5);
      check(lcorr, 32'h19, "sync residence");
      send_fwd(PDRR_FOLLOW, 48'h1234, 32'h7);
      check(lstamp, 48'h1234, "forwarded stamp");
      check(lcorr, 32'h1b, "follow-up residence");
      wait_cnt(2, 1);
      check(up_slot, 1'h1, "second server request");
      wait_cnt(1, 1);
      @(negedge clk_in);
      check(busy_out, 1'h0, "idle after timeout");
      $display("test forwarding done");
      report_and_stop();
   end
endmodule
`default_nettype wire
